// ==== hw/csf_status_flags.sv ====
// processor status flag register with interrupt gating
// assumes inputs synchronous to clock; core supplies event strobes
//
// Overview of operation
// - bank flag picks general register bank
// - overflow flag follows each integer result update
// - enable flag gates maskable interrupts
// - accepting any interrupt clears enable flag
// - stack flag picks interrupt or user stack
// - interrupt or low trap forces interrupt stack
// - float underflow on underflow or subnormal operand
// - float overflow on overflow or subnormal operand
// - priority level is three bits, 0 to 7
// - request level must exceed priority level
// - level seven blocks every request
// - radix bit picks fixed-point product slice
// - two-bit field selects float rounding
// - reserved bit written zero, reads zero
`timescale 1ns/100ps
`default_nettype none
module csf_status_flags
  import csf_pkg::*;
#(
  parameter int unsigned LEVEL_BITS = 3
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // software write of the whole flag word
  input  wire logic                   flagWrite,
  input  wire logic [FLAG_WIDTH-1:0]  flagWriteData,
  // integer result update
  input  wire logic                   intUpdate,
  input  wire logic                   intOverflow,
  // float result update
  input  wire logic                   floatUpdate,
  input  wire logic                   floatUnderflow,
  input  wire logic                   floatOverflow,
  input  wire logic                   floatSubnormal,
  // interrupt requests
  input  wire logic                   irqMaskable,
  input  wire logic                   irqValid,
  input  wire logic [LEVEL_BITS-1:0]  irqLevel,
  input  wire logic                   irqTaken,
  // software trap
  input  wire logic                   trapExec,
  input  wire logic [7:0]             trapVector,
  // flag word and decoded selects
  output logic [FLAG_WIDTH-1:0]       flagWord,
  output logic                        bankSelect,
  output logic                        useUserStack,
  output logic                        useInterruptStack,
  output logic                        radixPointSelect,
  output logic [1:0]                  roundingSelect,
  output logic [LEVEL_BITS-1:0]       cpuPriorityLevel,
  output logic                        irqAccept
);

  ////////////////////////////////////////////////////////////////////////
  // flag state
  logic                  bankFlag;
  logic                  ovfFlag;
  logic                  ienFlag;
  logic                  stackFlag;
  logic                  funderFlag;
  logic                  foverFlag;
  logic [LEVEL_BITS-1:0] levelField;
  logic                  radixFlag;
  logic [1:0]            roundField;
  logic                  next_bankFlag;
  logic                  next_ovfFlag;
  logic                  next_ienFlag;
  logic                  next_stackFlag;
  logic                  next_funderFlag;
  logic                  next_foverFlag;
  logic [LEVEL_BITS-1:0] next_levelField;
  logic                  next_radixFlag;
  logic [1:0]            next_roundField;
  logic                  eligible;
  logic                  lowTrap;

  ////////////////////////////////////////////////////////////////////////
  // acceptance decision
  always_comb begin
    eligible = irqValid
             && (levelField != LEVEL_BITS'(LEVEL_ALL_OFF))
             && (irqLevel > levelField);
    if (irqMaskable) begin
      eligible = eligible && ienFlag;
    end
    lowTrap = trapExec && (trapVector <= TRAP_STACK_MAX);
  end

  ////////////////////////////////////////////////////////////////////////
  // next flag values
  always_comb begin
    next_bankFlag   = bankFlag;
    next_ovfFlag    = ovfFlag;
    next_ienFlag    = ienFlag;
    next_stackFlag  = stackFlag;
    next_funderFlag = funderFlag;
    next_foverFlag  = foverFlag;
    next_levelField = levelField;
    next_radixFlag  = radixFlag;
    next_roundField = roundField;
    if (flagWrite) begin
      next_bankFlag   = flagWriteData[POS_BANK];
      next_ovfFlag    = flagWriteData[POS_OVF];
      next_ienFlag    = flagWriteData[POS_IEN];
      next_stackFlag  = flagWriteData[POS_STACK];
      next_funderFlag = flagWriteData[POS_FUNDER];
      next_foverFlag  = flagWriteData[POS_FOVER];
      next_levelField = flagWriteData[POS_LEVEL +: LEVEL_BITS];
      next_radixFlag  = flagWriteData[POS_RADIX];
      next_roundField = flagWriteData[POS_ROUND +: ROUND_WIDTH];
    end
    if (intUpdate) begin
      next_ovfFlag = intOverflow;
    end
    if (floatUpdate) begin
      next_funderFlag = floatUnderflow || floatSubnormal;
      next_foverFlag  = floatOverflow || floatSubnormal;
    end
    if (lowTrap) begin
      next_stackFlag = SEL_INT_STACK;
    end
    if (irqTaken) begin
      next_ienFlag   = 1'h0;
      next_stackFlag = SEL_INT_STACK;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      bankFlag   <= RST_BANK;
      ovfFlag    <= RST_OVF;
      ienFlag    <= RST_IEN;
      stackFlag  <= RST_STACK;
      funderFlag <= RST_FUNDER;
      foverFlag  <= RST_FOVER;
      levelField <= LEVEL_BITS'(RST_LEVEL);
      radixFlag  <= RST_RADIX;
      roundField <= RST_ROUND;
    end else begin
      bankFlag   <= next_bankFlag;
      ovfFlag    <= next_ovfFlag;
      ienFlag    <= next_ienFlag;
      stackFlag  <= next_stackFlag;
      funderFlag <= next_funderFlag;
      foverFlag  <= next_foverFlag;
      levelField <= next_levelField;
      radixFlag  <= next_radixFlag;
      roundField <= next_roundField;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [FLAG_WIDTH-1:0] next_flagWord;
  logic                  next_useUserStack;
  logic                  next_useInterruptStack;
  logic                  next_irqAccept;

  always_comb begin
    next_flagWord = '0;
    next_flagWord[POS_BANK]   = next_bankFlag;
    next_flagWord[POS_OVF]    = next_ovfFlag;
    next_flagWord[POS_IEN]    = next_ienFlag;
    next_flagWord[POS_STACK]  = next_stackFlag;
    next_flagWord[POS_FUNDER] = next_funderFlag;
    next_flagWord[POS_FOVER]  = next_foverFlag;
    next_flagWord[POS_LEVEL +: LEVEL_BITS]  = next_levelField;
    next_flagWord[POS_RADIX]  = next_radixFlag;
    next_flagWord[POS_ROUND +: ROUND_WIDTH] = next_roundField;
    next_useUserStack      = (next_stackFlag == SEL_USER_STACK);
    next_useInterruptStack = (next_stackFlag == SEL_INT_STACK);
    next_irqAccept         = eligible && !irqTaken;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      flagWord          <= '0;
      bankSelect        <= RST_BANK;
      useUserStack      <= 1'h0;
      useInterruptStack <= 1'h1;
      radixPointSelect  <= RST_RADIX;
      roundingSelect    <= RST_ROUND;
      cpuPriorityLevel  <= LEVEL_BITS'(RST_LEVEL);
      irqAccept         <= 1'h0;
    end else begin
      flagWord          <= next_flagWord;
      bankSelect        <= next_bankFlag;
      useUserStack      <= next_useUserStack;
      useInterruptStack <= next_useInterruptStack;
      radixPointSelect  <= next_radixFlag;
      roundingSelect    <= next_roundField;
      cpuPriorityLevel  <= next_levelField;
      irqAccept         <= next_irqAccept;
    end
  end

endmodule
`default_nettype wire

// ==== pkg/csf_pkg.sv ====
// constants for the processor status flag register block
// assumes a single clock and synchronous active-low reset
`default_nettype none
package csf_pkg;
  // flag word layout (flag word is also an output of this block)
  localparam int unsigned FLAG_WIDTH    = 32;
  localparam int unsigned POS_BANK      = 0;
  localparam int unsigned POS_OVF       = 1;
  localparam int unsigned POS_IEN       = 2;
  localparam int unsigned POS_STACK     = 3;
  localparam int unsigned POS_FUNDER    = 4;
  localparam int unsigned POS_FOVER     = 5;
  localparam int unsigned POS_LEVEL     = 8;
  localparam int unsigned LEVEL_WIDTH   = 3;
  localparam int unsigned POS_RADIX     = 11;
  localparam int unsigned POS_ROUND     = 12;
  localparam int unsigned ROUND_WIDTH   = 2;
  localparam int unsigned POS_RESERVED  = 14;
  // reset values
  localparam logic       RST_BANK   = 1'h0;
  localparam logic       RST_OVF    = 1'h0;
  localparam logic       RST_IEN    = 1'h0;
  localparam logic       RST_STACK  = 1'h0;
  localparam logic       RST_FUNDER = 1'h0;
  localparam logic       RST_FOVER  = 1'h0;
  localparam logic [2:0] RST_LEVEL  = 3'h0;
  localparam logic       RST_RADIX  = 1'h0;
  localparam logic [1:0] RST_ROUND  = 2'h0;
  // level at which every request is refused
  localparam logic [2:0] LEVEL_ALL_OFF = 3'h7;
  // highest trap vector that forces the interrupt stack
  localparam logic [7:0] TRAP_STACK_MAX = 8'h7F;
  // stack selection codes
  localparam logic SEL_INT_STACK  = 1'h0;
  localparam logic SEL_USER_STACK = 1'h1;
endpackage
`default_nettype wire

// ==== verification/csf_checker.sv ====
// assertions on the status flag block ports
// assumes binding into csf_status_flags, one clock domain
`timescale 1ns/100ps
`default_nettype none
module csf_checker
  import csf_pkg::*;
#(parameter int unsigned LEVEL_BITS = 3) (
  input wire logic clock, resetn, intUpdate, intOverflow, floatUpdate,
  input wire logic floatUnderflow, floatOverflow, floatSubnormal,
  input wire logic irqMaskable, irqValid, irqTaken, trapExec,
  input wire logic [LEVEL_BITS-1:0] irqLevel, cpuPriorityLevel,
  input wire logic [7:0] trapVector,
  input wire logic [FLAG_WIDTH-1:0] flagWord,
  input wire logic bankSelect, useUserStack, useInterruptStack, irqAccept
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  ovf_follow_a: assert property (intUpdate |-> ##1
    flagWord[POS_OVF] == $past(intOverflow)) else $error("ovf flag");
  funder_follow_a: assert property (floatUpdate |-> ##1
    flagWord[POS_FUNDER] == $past(floatUnderflow || floatSubnormal))
    else $error("underflow flag");
  fover_follow_a: assert property (floatUpdate |-> ##1
    flagWord[POS_FOVER] == $past(floatOverflow || floatSubnormal))
    else $error("overflow flag");
  ien_clear_a: assert property (irqTaken |-> ##1
    !flagWord[POS_IEN] && !irqAccept) else $error("enable not cleared");
  stack_force_a: assert property (irqTaken || trapExec &&
    trapVector <= TRAP_STACK_MAX |-> ##1 !flagWord[POS_STACK] &&
    useInterruptStack) else $error("stack not forced");
  stack_decode_a: assert property (useUserStack ==
    flagWord[POS_STACK] && useInterruptStack != useUserStack)
    else $error("stack decode");
  bank_decode_a: assert property (bankSelect ==
    flagWord[POS_BANK]) else $error("bank decode");
  level_above_a: assert property (irqAccept |->
    $past(irqValid) && $past(irqLevel) > $past(cpuPriorityLevel))
    else $error("accept at low level");
  level_off_a: assert property (irqAccept |->
    $past(cpuPriorityLevel) != LEVEL_ALL_OFF)
    else $error("accept at level 7");
  mask_gate_a: assert property (irqAccept && $past(irqMaskable) |->
    $past(flagWord[POS_IEN])) else $error("masked accept");
  cover property (irqAccept && $past(irqMaskable));
  cover property (irqTaken);
  cover property (trapExec && trapVector > TRAP_STACK_MAX);
endmodule
`default_nettype wire

// ==== verification/cpu_status_flag_register_tb_top.sv ====
// directed bench for the status flag block
// assumes csf_pkg and csf_status_flags compiled first
`timescale 1ns/100ps
`default_nettype none
module cpu_status_flag_register_tb_top;
  import csf_pkg::*;
  logic clock = 0, resetn = 0, flagWrite = 0, intUpdate = 0;
  logic intOverflow = 0, floatUpdate = 0, floatUnderflow = 0;
  logic floatOverflow = 0, floatSubnormal = 0, irqMaskable = 0;
  logic irqValid = 0, irqTaken = 0, trapExec = 0, irqAccept;
  logic bankSelect, useUserStack, useInterruptStack, radixPointSelect;
  logic [2:0]  irqLevel = 0, cpuPriorityLevel;
  logic [1:0]  roundingSelect;
  logic [7:0]  trapVector = 0;
  logic [31:0] flagWriteData = 0, flagWord;
  int n_errors = 0, compares = 0, cycles = 0;
  csf_status_flags dut_u (.clock, .resetn, .flagWrite, .flagWriteData,
    .intUpdate, .intOverflow, .floatUpdate, .floatUnderflow, .floatOverflow,
    .floatSubnormal, .irqMaskable, .irqValid, .irqLevel, .irqTaken,
    .trapExec, .trapVector, .flagWord, .bankSelect, .useUserStack,
    .useInterruptStack, .radixPointSelect, .roundingSelect,
    .cpuPriorityLevel, .irqAccept);
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task report_and_stop();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(logic [31:0] d);
    flagWrite = 1;
    flagWriteData = d;
    cyc(1);
    flagWrite = 0;
    cyc(3);
  endtask
  task t_write();
    wr(32'h00002D09);
    chk("word", flagWord, 32'h00002D09);
    chk("user", {useUserStack, useInterruptStack}, 32'h2);
    chk("level", cpuPriorityLevel, 32'h5);
    chk("radix", radixPointSelect, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr({18'h0, i[1:0], 12'h0} | i[0]);
      chk("round", roundingSelect, i);
      chk("bank", bankSelect, i[0]);
    end
    $display("test done: write");
  endtask
  task t_arith();
    for (int i = 0; i < 10; i++) begin
      {intUpdate, floatUpdate} = (i < 8) ? 2'h1 : 2'h2;
      {floatSubnormal, floatOverflow, floatUnderflow} = i[2:0];
      intOverflow = !i[0];
      cyc(1);
      {intUpdate, floatUpdate} = 2'h0;
      cyc(3);
      if (i < 8) chk("fu", flagWord[4], i[0] | i[2]);
      if (i < 8) chk("fo", flagWord[5], i[1] | i[2]);
      else chk("ovf", flagWord[1], !i[0]);
    end
    $display("test done: arith");
  endtask
  task t_irq();
    wr(32'h00000304);
    {irqValid, irqMaskable} = 2'h3;
    for (int lv = 0; lv < 8; lv++) begin
      irqLevel = lv;
      cyc(2);
      chk("accept", irqAccept, lv > 3);
    end
    wr(32'h00000300);
    chk("masked", irqAccept, 32'h0);
    irqMaskable = 0;
    cyc(2);
    chk("nonmask", irqAccept, 32'h1);
    wr(32'h00000700);
    chk("lvl7", irqAccept, 32'h0);
    wr(32'h0000030C);
    irqTaken = 1;
    cyc(1);
    {irqTaken, irqValid} = 2'h0;
    cyc(3);
    chk("taken", flagWord, 32'h00000300);
    chk("isp", useInterruptStack, 32'h1);
    $display("test done: irq");
  endtask
  task automatic t_trap();
    logic [7:0] v[3] = '{8'h00, 8'h7F, 8'h80};
    foreach (v[k]) begin
      wr(32'h00000008);
      trapExec = 1;
      trapVector = v[k];
      cyc(1);
      trapExec = 0;
      cyc(3);
      chk("trap", flagWord[3], v[k] > 8'h7F);
    end
    $display("test done: trap");
  endtask
  initial begin
    cyc(3);
    chk("rst", flagWord, 32'h0);
    chk("rst isp", {useInterruptStack, irqAccept}, 32'h2);
    resetn = 1;
    t_write();
    t_arith();
    t_irq();
    t_trap();
    report_and_stop();
  end
endmodule
bind csf_status_flags csf_checker #(.LEVEL_BITS(LEVEL_BITS)) chk_u (
  .clock, .resetn, .intUpdate, .intOverflow, .floatUpdate, .floatUnderflow,
  .floatOverflow, .floatSubnormal, .irqMaskable, .irqValid, .irqTaken,
  .trapExec, .irqLevel, .cpuPriorityLevel, .trapVector, .flagWord,
  .bankSelect, .useUserStack, .useInterruptStack, .irqAccept);
`default_nettype wire
